/* include/ctts_pkg.sv */
`default_nettype none
package ctts_pkg;
    // bus shape
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int TS_W   = 32;

    // register offsets
    localparam logic [7:0] OFS_CTRL     = 8'h00;
    localparam logic [7:0] OFS_PERIOD   = 8'h04;
    localparam logic [7:0] OFS_WIDTH    = 8'h08;
    localparam logic [7:0] OFS_TIME     = 8'h0c;
    localparam logic [7:0] OFS_STATUS   = 8'h10;
    localparam logic [7:0] OFS_SEQ_IDX  = 8'h14;
    localparam logic [7:0] OFS_SEQ_DATA = 8'h18;
    localparam logic [7:0] OFS_SEQ_LAST = 8'h1c;
    localparam logic [7:0] OFS_LAST_TS  = 8'h20;

    // control field positions
    localparam int CTRL_W       = 5;
    localparam int CB_TRIG0_EN  = 0;
    localparam int CB_TRIG1_EN  = 1;
    localparam int CB_SYNC_EN   = 2;
    localparam int CB_TS_FRAME  = 3;
    localparam int CB_VCAM_SEL  = 4;

    // status field positions
    localparam int SB_BUSY      = 0;
    localparam int SB_SYNC_LVL  = 1;
    localparam int SB_PULSE     = 2;
    localparam int SB_DROP_LO   = 8;
    localparam int DROP_W       = 8;

    // reset values
    localparam logic [CTRL_W-1:0] CTRL_RST   = 5'h00;
    localparam logic [TS_W-1:0]   PERIOD_RST = 32'h0000_8235;
    localparam logic [TS_W-1:0]   WIDTH_RST  = 32'h0000_0064;
    localparam logic [TS_W-1:0]   ZERO_TS    = 32'h0000_0000;
    localparam logic [TS_W-1:0]   ONE_TS     = 32'h0000_0001;

    // timing: one timestamp unit is one microsecond
    localparam int CLK_PERIOD_NS = 100;
    localparam int US_NS         = 1000;
    localparam int TICK_CYCLES   = US_NS / CLK_PERIOD_NS;
    localparam int TICK_W        = 4;
    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);

    // stored virtual sequence
    localparam int SEQ_AW = 4;
    localparam int SEQ_DW = 32;

    typedef enum logic [0:0] {
        PS_IDLE = 1'b0,
        PS_BUSY = 1'b1
    } ctts_proc_e;
endpackage
`default_nettype wire

/* rtl/ctts_seq_mem.sv */
`timescale 1ns/100ps
`default_nettype none
module ctts_seq_mem
    import ctts_pkg::*;
(
    // clock and reset
    input  wire logic              clk,
    input  wire logic              reset_n,
    // write port
    input  wire logic              wr_en,
    input  wire logic [SEQ_AW-1:0] wr_addr,
    input  wire logic [SEQ_DW-1:0] wr_data,
    // read port, data one cycle later
    input  wire logic [SEQ_AW-1:0] rd_addr,
    output var  logic [SEQ_DW-1:0] rd_data_ff
);
    logic [SEQ_DW-1:0] mem [0:(1<<SEQ_AW)-1];

    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            rd_data_ff <= '0;
        end else begin
            rd_data_ff <= mem[rd_addr];
        end
    end
endmodule // ctts_seq_mem
`default_nettype wire

/* rtl/ctts_top.sv */
// The register addresses and the address-and-strobe port were decided locally.
`timescale 1ns/100ps
`default_nettype none
module ctts_top
    import ctts_pkg::*;
(
    // clock and reset
    input  wire logic              clk,
    input  wire logic              reset_n,
    // register port
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [DATA_W-1:0] reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output var  logic [DATA_W-1:0] reg_rdata_ff,
    // trigger pins
    output var  logic              trig0_ff,
    output var  logic              trig1_out_ff,
    output var  logic              trig1_oe_ff,
    input  wire logic              trig1_in,
    // camera and processing handshake
    input  wire logic              cam_frame_valid,
    input  wire logic              proc_done,
    // virtual camera frame request
    output var  logic              vcam_frame_valid_ff,
    output var  logic [SEQ_DW-1:0] vcam_frame_addr,
    // result stream
    output var  logic              result_valid_ff,
    output var  logic [TS_W-1:0]   result_ts_ff,
    output var  logic [TS_W-1:0]   result_seq_ff,
    output var  logic              result_left_valid_ff,
    // indicators
    output var  logic              busy_led_ff,
    output var  logic              power_led_ff
);
    ////////////////////////////////////////////////////////////////////////
    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [ADDR_W-1:0] ofs);
        hit = (a == ofs);
    endfunction

    logic [CTRL_W-1:0] ctrl_ff;
    logic [TS_W-1:0]   period_ff;
    logic [TS_W-1:0]   width_ff;
    logic [SEQ_AW-1:0] seq_widx_ff;
    logic [SEQ_AW-1:0] seq_last_ff;
    logic [TICK_W-1:0] tick_cnt_ff;
    logic [TS_W-1:0]   ts_ff;
    logic [TS_W-1:0]   period_cnt_ff;
    logic [TS_W-1:0]   width_cnt_ff;
    logic              pulse_on_ff;
    logic              sync_meta_ff;
    logic              sync_lvl_ff;
    logic              sync_prev_ff;
    logic [TS_W-1:0]   pend_ts_ff;
    logic [TS_W-1:0]   work_ts_ff;
    ctts_proc_e        state_ff;
    ctts_proc_e        nxt_state;
    logic [DROP_W-1:0] drop_ff;
    logic [SEQ_AW-1:0] vcam_idx_ff;
    logic              vcam_rd_ff;
    logic              us_tick;
    logic              trig_start;
    logic              sync_rise;
    logic              sync_en;
    logic              frame_evt;
    logic              seq_wr;
    logic [DATA_W-1:0] nxt_rdata;

    assign sync_en = ctrl_ff[CB_SYNC_EN];
    assign seq_wr  = reg_wr && hit(reg_addr, OFS_SEQ_DATA);

    ////////////////////////////////////////////////////////////////////////
    // registers written by software
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ctrl_ff     <= CTRL_RST;
            period_ff   <= PERIOD_RST;
            width_ff    <= WIDTH_RST;
            seq_widx_ff <= '0;
            seq_last_ff <= '0;
        end else if (reg_wr) begin
            if (hit(reg_addr, OFS_CTRL)) begin
                ctrl_ff <= reg_wdata[CTRL_W-1:0];
            end
            if (hit(reg_addr, OFS_PERIOD)) begin
                period_ff <= reg_wdata;
            end
            if (hit(reg_addr, OFS_WIDTH)) begin
                width_ff <= reg_wdata;
            end
            if (hit(reg_addr, OFS_SEQ_IDX)) begin
                seq_widx_ff <= reg_wdata[SEQ_AW-1:0];
            end
            if (hit(reg_addr, OFS_SEQ_LAST)) begin
                seq_last_ff <= reg_wdata[SEQ_AW-1:0];
            end
        end
    end

    // read data stands in the cycle after the strobe only
    always_comb begin
        nxt_rdata = '0;
        case (reg_addr)
            OFS_CTRL:     nxt_rdata = {{(DATA_W-CTRL_W){1'b0}}, ctrl_ff};
            OFS_PERIOD:   nxt_rdata = period_ff;
            OFS_WIDTH:    nxt_rdata = width_ff;
            OFS_TIME:     nxt_rdata = ts_ff;
            OFS_STATUS: begin
                nxt_rdata[SB_BUSY]     = (state_ff == PS_BUSY);
                nxt_rdata[SB_SYNC_LVL] = sync_lvl_ff;
                nxt_rdata[SB_PULSE]    = pulse_on_ff;
                nxt_rdata[SB_DROP_LO +: DROP_W] = drop_ff;
            end
            OFS_SEQ_IDX:  nxt_rdata = {{(DATA_W-SEQ_AW){1'b0}}, seq_widx_ff};
            OFS_SEQ_LAST: nxt_rdata = {{(DATA_W-SEQ_AW){1'b0}}, seq_last_ff};
            OFS_LAST_TS:  nxt_rdata = result_ts_ff;
            default:      nxt_rdata = '0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            reg_rdata_ff <= '0;
        end else begin
            reg_rdata_ff <= reg_rd ? nxt_rdata : '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // microsecond tick and timestamp clock
    assign us_tick = (tick_cnt_ff == TICK_LAST);

    always_ff @(posedge clk) begin
        if (!reset_n || sync_rise) begin
            tick_cnt_ff <= '0;
        end else if (us_tick) begin
            tick_cnt_ff <= '0;
        end else begin
            tick_cnt_ff <= tick_cnt_ff + TICK_W'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ts_ff <= ZERO_TS;
        end else if (sync_rise) begin
            ts_ff <= ZERO_TS;
        end else if (us_tick) begin
            ts_ff <= ts_ff + ONE_TS;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sync input: two flops, then edge detect on the second
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            sync_meta_ff <= 1'b0;
            sync_lvl_ff  <= 1'b0;
            sync_prev_ff <= 1'b0;
        end else begin
            sync_meta_ff <= trig1_in;
            sync_lvl_ff  <= sync_meta_ff;
            sync_prev_ff <= sync_lvl_ff;
        end
    end

    assign sync_rise = sync_en && sync_lvl_ff && !sync_prev_ff;

    ////////////////////////////////////////////////////////////////////////
    // trigger period and pulse width, both in microseconds
    assign trig_start = us_tick && (period_ff != ZERO_TS) &&
                        (period_cnt_ff == ZERO_TS);

    // a new period restarts the count instead of waiting out the old one
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            period_cnt_ff <= ZERO_TS;
        end else if (reg_wr && hit(reg_addr, OFS_PERIOD)) begin
            period_cnt_ff <= ZERO_TS;
        end else if (us_tick) begin
            if (period_cnt_ff == ZERO_TS) begin
                period_cnt_ff <= (period_ff == ZERO_TS) ? ZERO_TS
                                                        : period_ff - ONE_TS;
            end else begin
                period_cnt_ff <= period_cnt_ff - ONE_TS;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            pulse_on_ff  <= 1'b0;
            width_cnt_ff <= ZERO_TS;
        end else if (trig_start) begin
            pulse_on_ff  <= (width_ff != ZERO_TS);
            width_cnt_ff <= width_ff;
        end else if (us_tick && pulse_on_ff) begin
            pulse_on_ff  <= (width_cnt_ff != ONE_TS);
            width_cnt_ff <= width_cnt_ff - ONE_TS;
        end
    end

    // one shared pulse keeps both outputs edge aligned
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            trig0_ff     <= 1'b0;
            trig1_out_ff <= 1'b0;
            trig1_oe_ff  <= 1'b1;
        end else begin
            trig0_ff     <= pulse_on_ff && ctrl_ff[CB_TRIG0_EN];
            trig1_out_ff <= pulse_on_ff && ctrl_ff[CB_TRIG1_EN] && !sync_en;
            trig1_oe_ff  <= !sync_en;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // virtual camera replay
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            vcam_idx_ff <= '0;
            vcam_rd_ff  <= 1'b0;
        end else begin
            vcam_rd_ff <= trig_start && ctrl_ff[CB_VCAM_SEL];
            // step after the read so replay opens with the first entry
            if (!ctrl_ff[CB_VCAM_SEL]) begin
                vcam_idx_ff <= '0;
            end else if (vcam_rd_ff) begin
                vcam_idx_ff <= (vcam_idx_ff >= seq_last_ff) ? '0
                             : vcam_idx_ff + SEQ_AW'(1);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            vcam_frame_valid_ff <= 1'b0;
        end else begin
            vcam_frame_valid_ff <= vcam_rd_ff;
        end
    end

    ctts_seq_mem u_seq_mem (
        .clk        (clk),
        .reset_n    (reset_n),
        .wr_en      (seq_wr),
        .wr_addr    (seq_widx_ff),
        .wr_data    (reg_wdata),
        .rd_addr    (vcam_idx_ff),
        .rd_data_ff (vcam_frame_addr)
    );

    assign frame_evt = ctrl_ff[CB_VCAM_SEL] ? vcam_frame_valid_ff : cam_frame_valid;

    ////////////////////////////////////////////////////////////////////////
    // timestamp capture source
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            pend_ts_ff <= ZERO_TS;
        end else if (trig_start) begin
            pend_ts_ff <= ts_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // processing state
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            PS_IDLE: if (frame_evt) nxt_state = PS_BUSY;
            PS_BUSY: if (proc_done) nxt_state = PS_IDLE;
            default: nxt_state = PS_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_ff    <= PS_IDLE;
            busy_led_ff <= 1'b0;
        end else begin
            state_ff    <= nxt_state;
            busy_led_ff <= (nxt_state == PS_BUSY);
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            work_ts_ff <= ZERO_TS;
        end else if (state_ff == PS_IDLE && frame_evt) begin
            work_ts_ff <= ctrl_ff[CB_TS_FRAME] ? ts_ff : pend_ts_ff;
        end
    end

    // frames arriving while busy are dropped; those outside the proc_done cycle are counted
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            drop_ff <= '0;
        end else if (state_ff == PS_BUSY && frame_evt && !proc_done &&
                     drop_ff != '1) begin
            drop_ff <= drop_ff + DROP_W'(1);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // result stream
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            result_valid_ff      <= 1'b0;
            result_left_valid_ff <= 1'b0;
            result_ts_ff         <= ZERO_TS;
            result_seq_ff        <= ZERO_TS;
        end else begin
            result_valid_ff      <= (state_ff == PS_BUSY) && proc_done;
            result_left_valid_ff <= (state_ff == PS_BUSY) && proc_done;
            if (state_ff == PS_BUSY && proc_done) begin
                result_ts_ff  <= work_ts_ff;
                result_seq_ff <= result_seq_ff + ONE_TS;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            power_led_ff <= 1'b0;
        end else begin
            power_led_ff <= 1'b1;
        end
    end
endmodule // ctts_top
`default_nettype wire

/* tb/ctts_props.sv */
`timescale 1ns/100ps
`default_nettype none
module ctts_props
    import ctts_pkg::*;
(
    // clock and reset
    input wire logic              clk,
    input wire logic              reset_n,
    // watched ports
    input wire logic              reg_rd,
    input wire logic [DATA_W-1:0] reg_rdata_ff,
    input wire logic              trig1_out_ff,
    input wire logic              trig1_oe_ff,
    input wire logic              cam_frame_valid,
    input wire logic              proc_done,
    input wire logic              vcam_frame_valid_ff,
    input wire logic              result_valid_ff,
    input wire logic [TS_W-1:0]   result_ts_ff,
    input wire logic [TS_W-1:0]   result_seq_ff,
    input wire logic              result_left_valid_ff,
    input wire logic              busy_led_ff,
    input wire logic              power_led_ff
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    ////////////////////////////////////////////////////////////
    a_pin_drive: assert property (trig1_out_ff |-> trig1_oe_ff)
        else $error("trigger 1 value without output enable");
    a_busy_cause: assert property ($rose(busy_led_ff) |->
        $past(cam_frame_valid) || $past(vcam_frame_valid_ff))
        else $error("busy rose without a frame");
    a_done_result: assert property (proc_done && busy_led_ff |=>
        result_valid_ff && !busy_led_ff)
        else $error("finish did not give a result");
    a_busy_end: assert property ($fell(busy_led_ff) |-> result_valid_ff)
        else $error("busy fell without a result");
    a_left_pair: assert property (result_left_valid_ff == result_valid_ff)
        else $error("left image flag apart from result");
    a_seq_step: assert property (result_valid_ff |->
        result_seq_ff == $past(result_seq_ff) + 32'h1)
        else $error("sequence did not step by one");
    a_ts_hold: assert property (!result_valid_ff |-> $stable(result_ts_ff))
        else $error("timestamp moved between results");
    a_power_on: assert property (reset_n |=> power_led_ff)
        else $error("power indicator off while running");
    a_rd_idle: assert property (!reg_rd |=> reg_rdata_ff == 32'h0)
        else $error("read data outside read cycle");
endmodule // ctts_props
`default_nettype wire

/* tb/ctts_cam_model.sv */
`timescale 1ns/100ps
`default_nettype none
module ctts_cam_model #(
    parameter int LAT     = 4,
    parameter int FALL    = 0,
    parameter int PPS_CYC = 400
) (
    // clock
    input  wire logic clk,
    // trigger pins
    input  wire logic trig0,
    input  wire logic trig1_out,
    input  wire logic trig1_oe,
    // pulse source control
    input  wire logic pps_on,
    // camera and pin
    output var  logic frame_valid,
    output wire logic pin
);
    logic t_q   = 1'b0;
    int   lat   = 0;
    int   cnt   = 0;
    logic pps_lvl;
    initial frame_valid = 1'b0;
    always @(posedge clk) begin
        t_q <= trig0;
        frame_valid <= (lat == 1);
        if (FALL != 0 ? (t_q && !trig0) : (trig0 && !t_q))
            lat <= LAT;
        else if (lat != 0)
            lat <= lat - 1;
        cnt <= (pps_on && cnt < PPS_CYC - 1) ? cnt + 1 : 0;
    end
    // one rising edge per scaled second, pulled low when idle
    assign pps_lvl = pps_on && (cnt < PPS_CYC / 2);
    assign pin     = trig1_oe ? trig1_out : pps_lvl;
endmodule // ctts_cam_model
`default_nettype wire

/* tb/ctts_top_test.sv */
`timescale 1ns/100ps
`default_nettype none
module ctts_top_test
    import ctts_pkg::*;
;
    typedef struct packed {
        logic              wr;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic [DATA_W-1:0] exp;
    } ctts_row_s;
    localparam logic [DATA_W-1:0] PER = 32'h5;
    localparam logic [DATA_W-1:0] WID = 32'h2;
    localparam ctts_row_s ROWS [9] = '{
        '{1'b0, OFS_TIME, 32'h0, ZERO_TS},
        '{1'b0, OFS_CTRL, 32'h0, 32'h0},
        '{1'b0, OFS_PERIOD, 32'h0, PERIOD_RST},
        '{1'b0, OFS_WIDTH, 32'h0, WIDTH_RST},
        '{1'b0, OFS_STATUS, 32'h0, 32'h0},
        '{1'b0, 8'h24, 32'h0, 32'h0},
        '{1'b1, OFS_PERIOD, PER, PER},
        '{1'b1, OFS_WIDTH, WID, WID},
        '{1'b1, OFS_SEQ_DATA, 32'h77, 32'h0}};
    logic              clk = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic              proc_done = 1'b0, pps_on = 1'b0;
    logic [ADDR_W-1:0] reg_addr = 8'h00;
    logic [DATA_W-1:0] reg_wdata = 32'h0, reg_rdata_ff, d;
    logic              trig0_ff, trig1_out_ff, trig1_oe_ff, trig1_in, cam_frame_valid;
    logic              vcam_frame_valid_ff, result_valid_ff, result_left_valid_ff;
    logic              busy_led_ff, power_led_ff;
    logic [SEQ_DW-1:0] vcam_frame_addr;
    logic [TS_W-1:0]   result_ts_ff, result_seq_ff;
    int                num_errors = 0, check_count = 0, i, k, n;
    always #50 clk = ~clk;
    ctts_top i_dut (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff), .trig0_ff(trig0_ff),
        .trig1_out_ff(trig1_out_ff), .trig1_oe_ff(trig1_oe_ff), .trig1_in(trig1_in),
        .cam_frame_valid(cam_frame_valid), .proc_done(proc_done),
        .vcam_frame_valid_ff(vcam_frame_valid_ff), .vcam_frame_addr(vcam_frame_addr),
        .result_valid_ff(result_valid_ff), .result_ts_ff(result_ts_ff),
        .result_seq_ff(result_seq_ff), .result_left_valid_ff(result_left_valid_ff),
        .busy_led_ff(busy_led_ff), .power_led_ff(power_led_ff));
    ctts_cam_model #(.LAT(4), .FALL(0), .PPS_CYC(400)) i_model (.clk(clk), .trig0(trig0_ff),
        .trig1_out(trig1_out_ff), .trig1_oe(trig1_oe_ff), .pps_on(pps_on),
        .frame_valid(cam_frame_valid), .pin(trig1_in));
    ////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
        v = reg_rdata_ff;
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        $display("Error watchdog expected finish seen hang");
        conclude();
    end
    ////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        for (i = 0; i < 9; i++) begin
            if (ROWS[i].wr)
                wr(ROWS[i].addr, ROWS[i].data);
            rd(ROWS[i].addr, d);
            chk("register", ROWS[i].exp, d);
        end
        chk("power", 32'h1, power_led_ff);
        chk("pin 1 drive", 32'h1, trig1_oe_ff);
        chk("trigger 0 idle", 32'h0, trig0_ff);
        $display("test registers done");
        wr(OFS_CTRL, 32'h3);
        // a pulse may already be running; skip it and measure a fresh one
        for (i = 0; i < 200 && trig0_ff !== 1'b1; i++) @(posedge clk);
        for (i = 0; i < 200 && trig0_ff === 1'b1; i++) @(posedge clk);
        for (i = 0; i < 200 && trig0_ff !== 1'b1; i++) @(posedge clk);
        chk("trigger 1 start", 32'h1, trig1_out_ff);
        for (n = 0; n < 200 && trig0_ff === 1'b1; n++) @(posedge clk);
        chk("pulse cycles", WID * TICK_CYCLES, n);
        for (n = 0; n < 200 && trig0_ff !== 1'b1; n++) @(posedge clk);
        chk("gap cycles", (PER - WID) * TICK_CYCLES, n);
        $display("test triggers done");
        for (k = 1; k <= 3; k++) begin
            for (i = 0; i < 200 && busy_led_ff !== 1'b1; i++) @(posedge clk);
            if (k == 3)
                repeat (60) @(posedge clk);
            proc_done <= 1'b1;
            @(posedge clk);
            proc_done <= 1'b0;
            @(posedge clk);
            chk("result", 32'h1, result_valid_ff);
            chk("sequence", k, result_seq_ff);
            chk("busy off", 32'h0, busy_led_ff);
        end
        // one frame lands during the trigger test, one during the long job
        rd(OFS_STATUS, d);
        chk("dropped", 32'h2, d[SB_DROP_LO +: DROP_W]);
        $display("test processing done");
        for (k = 0; k < 2; k++) begin
            wr(OFS_SEQ_IDX, k);
            wr(OFS_SEQ_DATA, 32'ha0 + k);
        end
        wr(OFS_SEQ_LAST, 32'h1);
        wr(OFS_CTRL, 32'h11);
        for (k = 0; k < 4; k++) begin
            for (i = 0; i < 100 && vcam_frame_valid_ff !== 1'b1; i++) @(posedge clk);
            chk("replay frame", 32'ha0 + k % 2, vcam_frame_addr);
            @(posedge clk);
        end
        $display("test replay done");
        wr(OFS_CTRL, 32'h5);
        repeat (3) @(posedge clk);
        chk("pin 1 released", 32'h0, trig1_oe_ff);
        pps_on <= 1'b1;
        for (k = 0; k < 2; k++) begin
            for (i = 0; i < 500 && trig1_in !== 1'b0; i++) @(posedge clk);
            for (i = 0; i < 500 && trig1_in !== 1'b1; i++) @(posedge clk);
            repeat (15) @(posedge clk);
            rd(OFS_TIME, d);
            chk("time after sync", 32'h1, d);
        end
        $display("test sync done");
        pps_on <= 1'b0;
        wr(OFS_CTRL, 32'h9);
        proc_done <= 1'b1;
        @(posedge clk);
        proc_done <= 1'b0;
        @(posedge clk);
        for (i = 0; i < 200 && busy_led_ff !== 1'b1; i++) @(posedge clk);
        // frames come on a tick plus seven cycles, so no tick falls before this read
        rd(OFS_TIME, d);
        proc_done <= 1'b1;
        @(posedge clk);
        proc_done <= 1'b0;
        @(posedge clk);
        chk("frame stamp", d, result_ts_ff);
        $display("test stamp done");
        conclude();
    end
endmodule // ctts_top_test
bind ctts_top ctts_props i_props (.clk(clk), .reset_n(reset_n), .reg_rd(reg_rd),
    .reg_rdata_ff(reg_rdata_ff), .trig1_out_ff(trig1_out_ff), .trig1_oe_ff(trig1_oe_ff),
    .cam_frame_valid(cam_frame_valid), .proc_done(proc_done),
    .vcam_frame_valid_ff(vcam_frame_valid_ff), .result_valid_ff(result_valid_ff),
    .result_ts_ff(result_ts_ff), .result_seq_ff(result_seq_ff),
    .result_left_valid_ff(result_left_valid_ff), .busy_led_ff(busy_led_ff),
    .power_led_ff(power_led_ff));
`default_nettype wire
